/* src/dio_opto_map.svh */
`ifndef DIO_OPTO_MAP_SVH
`define DIO_OPTO_MAP_SVH

// register offsets from the board base
`define DOE_OFS_DIR       4'h4
`define DOE_OFS_DATA      4'h5
`define DOE_OFS_EDGE_CFG  4'h6
`define DOE_OFS_LEVEL     4'h7
`define DOE_OFS_JUMPER    4'h8
`define DOE_OFS_IRQ       4'hb

// opto_edge_config and opto_level_and_edge field positions
`define DOE_CFG_ENABLE_LSB 0
`define DOE_CFG_SENSE_LSB  4
`define DOE_LVL_LEVEL_LSB  0
`define DOE_LVL_FLAG_LSB   4

// jumper_sense_status field position
`define DOE_JMP_FLAG_BIT   0

// interrupt_control_status field positions
`define DOE_IRQ_PORT_EN    0
`define DOE_IRQ_ISO_EN     1
`define DOE_IRQ_PORT_FLAG  2
`define DOE_IRQ_ISO_FLAG   3
`define DOE_IRQ_PORT_CLR   4
`define DOE_IRQ_ISO_CLR    5

// reset values
`define DOE_RST_DIR        4'h0
`define DOE_RST_DATA       4'h0
`define DOE_RST_EDGE_CFG   8'h00
`define DOE_RST_IRQ_EN     1'b0
`define DOE_RST_RDATA      8'h00

`endif

/* src/dio_opto_pkg.sv */
package dio_opto_pkg;

  typedef logic [3:0] line_vec_t;
  typedef logic [3:0] bus_addr_t;
  typedef logic [7:0] bus_byte_t;

  typedef struct packed {
    line_vec_t sense_select;
    line_vec_t enable;
  } edge_cfg_t;

endpackage : dio_opto_pkg

/* src/irq_ctl_if.sv */
`timescale 1ns/1ps

interface irq_ctl_if;
  logic enable;
  logic set;
  logic clear;
  logic flag;

  modport circuit (input enable, input set, input clear, output flag);
  modport owner   (output enable, output set, output clear, input flag);
endinterface : irq_ctl_if

/* src/irq_circuit.sv */
`timescale 1ns/1ps

module irq_circuit (
  input wire logic    clock,
  input wire logic    rst_n,
  irq_ctl_if.circuit  ctl
);

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl.flag <= 1'b0;
    end else begin
      ctl.flag <= ctl.enable & (ctl.set | (ctl.flag & ~ctl.clear)); // [R5] [R6] [R17] [R19]
    end
  end

  a_set_wins_clear: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
    ctl.enable && ctl.set |=> ctl.flag)
    else $error("interrupt flag lost an event");

  a_flag_holds: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
    ctl.flag && ctl.enable && !ctl.clear |=> ctl.flag)
    else $error("interrupt flag dropped without clear");

endmodule : irq_circuit

/* src/dio_opto_edge_interrupt.sv */
`timescale 1ns/1ps
`include "dio_opto_map.svh"

// Summary of operation
// [R1] four port lines via data register
// [R2] per-line direction bits select drive
// [R3] reset makes every line input
// [R4] enabled line change sets port flag
// [R5] clear write drops port request
// [R6] disabled port interrupt clears, stays quiet
// [R7] bus request is OR of circuits
// [R8] jumper readable; it inverts opto readback
// [R9] edge detection only on enabled channels
// [R10] sense select: 0 falling, 1 rising
// [R11] installed jumper turns voltage rise falling
// [R12] software writes edge config in one go
// [R13] level register: levels low, flags high
// [R14] reading levels clears edge flags
// [R15] edge flags stick until read
// [R16] enabled opto edge sets isolated flag
// [R17] clear write drops isolated request
// [R18] software disables opto interrupts by enable
// [R19] requests latch until software clears
module dio_opto_edge_interrupt
  import dio_opto_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst_n,
  input  wire bus_addr_t bus_addr,
  input  wire logic      bus_write,
  input  wire logic      bus_read,
  input  wire bus_byte_t bus_wdata,
  output bus_byte_t      bus_rdata,
  input  wire line_vec_t dio_in,
  output line_vec_t      dio_out,
  output line_vec_t      dio_oe_n,
  input  wire line_vec_t opto_high,
  input  wire logic      jumper_installed,
  input  wire logic [1:0] other_irq,
  output logic           bus_irq
);

  line_vec_t line_way_select;
  line_vec_t port_line_data;
  edge_cfg_t edge_cfg;
  logic      port_change_irq_enable;
  logic      isolated_irq_enable;
  line_vec_t isolated_edge_flags;
  line_vec_t next_edge_flags;
  line_vec_t isolated_input_levels;
  line_vec_t level_prev;
  line_vec_t new_edges;
  line_vec_t dio_meta;
  line_vec_t dio_sync;
  line_vec_t dio_prev;
  line_vec_t line_readback;
  line_vec_t opto_meta;
  line_vec_t opto_sync;
  logic      jumper_meta;
  logic      input_sense_jumper_flag;
  logic      port_change;
  logic      wr_dir;
  logic      wr_data;
  logic      wr_cfg;
  logic      wr_irq;
  logic      rd_level;
  logic      port_change_irq_clear;
  logic      isolated_irq_clear;
  bus_byte_t next_rdata;

  irq_ctl_if port_ctl ();
  irq_ctl_if iso_ctl ();

  assign wr_dir   = bus_write && (bus_addr == `DOE_OFS_DIR);
  assign wr_data  = bus_write && (bus_addr == `DOE_OFS_DATA);
  assign wr_cfg   = bus_write && (bus_addr == `DOE_OFS_EDGE_CFG);
  assign wr_irq   = bus_write && (bus_addr == `DOE_OFS_IRQ);
  assign rd_level = bus_read && (bus_addr == `DOE_OFS_LEVEL);

  assign port_change_irq_clear = wr_irq && bus_wdata[`DOE_IRQ_PORT_CLR];
  assign isolated_irq_clear    = wr_irq && bus_wdata[`DOE_IRQ_ISO_CLR];

  // pins and the jumper arrive from outside: two stages each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dio_meta                <= 4'h0;
      dio_sync                <= 4'h0;
      opto_meta               <= 4'h0;
      opto_sync               <= 4'h0;
      jumper_meta             <= 1'b0;
      input_sense_jumper_flag <= 1'b0;
    end else begin
      dio_meta                <= dio_in;
      dio_sync                <= dio_meta;
      opto_meta               <= opto_high;
      opto_sync               <= opto_meta;
      jumper_meta             <= jumper_installed;
      input_sense_jumper_flag <= jumper_meta;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_way_select <= `DOE_RST_DIR; // [R3]
    end else if (wr_dir) begin
      line_way_select <= bus_wdata[3:0]; // [R2]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_line_data <= `DOE_RST_DATA;
    end else if (wr_data) begin
      port_line_data <= bus_wdata[3:0]; // [R1]
    end
  end

  assign dio_out  = port_line_data; // [R1]
  assign dio_oe_n = ~line_way_select; // [R2] [R3]

  // output lines read back the latch, inputs the synchronised pin
  assign line_readback = (dio_sync & ~line_way_select) | (port_line_data & line_way_select); // [R1]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dio_prev <= 4'h0;
    end else begin
      dio_prev <= dio_sync;
    end
  end

  // lines driven by the port itself are not watched
  assign port_change = |((dio_sync ^ dio_prev) & ~line_way_select); // [R4]

  // all enables and senses land in one write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      edge_cfg <= `DOE_RST_EDGE_CFG;
    end else if (wr_cfg) begin
      edge_cfg <= bus_wdata; // [R12]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_change_irq_enable <= `DOE_RST_IRQ_EN;
      isolated_irq_enable    <= `DOE_RST_IRQ_EN;
    end else if (wr_irq) begin
      port_change_irq_enable <= bus_wdata[`DOE_IRQ_PORT_EN];
      isolated_irq_enable    <= bus_wdata[`DOE_IRQ_ISO_EN]; // [R18]
    end
  end

  // the jumper flips the logic meaning, and edges are judged on it
  assign isolated_input_levels = opto_sync ^ {4{input_sense_jumper_flag}}; // [R8] [R11]

  // a jumper change looks like an edge on every channel; move it only with edges disabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_prev <= 4'h0;
    end else begin
      level_prev <= isolated_input_levels;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_edge
      logic rising;
      logic falling;
      assign rising  = isolated_input_levels[ch] & ~level_prev[ch];
      assign falling = ~isolated_input_levels[ch] & level_prev[ch];
      assign new_edges[ch] = edge_cfg.enable[ch] & // [R9]
                             (edge_cfg.sense_select[ch] ? rising : falling); // [R10] [R11]
    end
  endgenerate

  // a fresh edge in the reading cycle survives the clear
  assign next_edge_flags = new_edges | (isolated_edge_flags & ~{4{rd_level}}); // [R14] [R15]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      isolated_edge_flags <= 4'h0;
    end else begin
      isolated_edge_flags <= next_edge_flags;
    end
  end

  assign port_ctl.enable = port_change_irq_enable; // [R6]
  assign port_ctl.set    = port_change; // [R4]
  assign port_ctl.clear  = port_change_irq_clear; // [R5]
  assign iso_ctl.enable  = isolated_irq_enable;
  assign iso_ctl.set     = |new_edges; // [R16]
  assign iso_ctl.clear   = isolated_irq_clear; // [R17]

  irq_circuit u_port_irq (
    .clock (clock),
    .rst_n (rst_n),
    .ctl   (port_ctl.circuit)
  );

  irq_circuit u_iso_irq (
    .clock (clock),
    .rst_n (rst_n),
    .ctl   (iso_ctl.circuit)
  );

  // the other two circuits of the board come in on other_irq
  assign bus_irq = port_ctl.flag | iso_ctl.flag | (|other_irq); // [R7]

  always_comb begin
    next_rdata = `DOE_RST_RDATA;
    unique case (bus_addr)
      `DOE_OFS_DIR:      next_rdata = {4'h0, line_way_select};
      `DOE_OFS_DATA:     next_rdata = {4'h0, line_readback}; // [R1]
      `DOE_OFS_EDGE_CFG: next_rdata = edge_cfg;
      `DOE_OFS_LEVEL:    next_rdata = {isolated_edge_flags, isolated_input_levels}; // [R13]
      `DOE_OFS_JUMPER:   next_rdata = {7'h00, input_sense_jumper_flag}; // [R8]
      `DOE_OFS_IRQ:      next_rdata = {4'h0, iso_ctl.flag, port_ctl.flag,
                                       isolated_irq_enable, port_change_irq_enable};
      default:           next_rdata = `DOE_RST_RDATA;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= `DOE_RST_RDATA;
    end else if (bus_read) begin
      bus_rdata <= next_rdata;
    end
  end

  sequence s_data_write;
    wr_data;
  endsequence

  sequence s_dir_write;
    wr_dir;
  endsequence

  sequence s_level_read_quiet;
    rd_level && (new_edges == 4'h0);
  endsequence

  a_line_data_write: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    s_data_write |=> dio_out == $past(bus_wdata[3:0]))
    else $error("port data not driven after write");

  a_dir_write_drive: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    s_dir_write |=> dio_oe_n == ~$past(bus_wdata[3:0]))
    else $error("line enables do not follow direction write");

  a_reset_all_inputs: assert property (@(posedge clock) // [R3]
    !rst_n |-> dio_oe_n == 4'hf)
    else $error("a line drives during reset");

  a_change_sets_flag: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    port_change_irq_enable && port_change |=> port_ctl.flag && bus_irq)
    else $error("line change missed by port interrupt");

  a_port_clear_drops: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    port_change_irq_clear && !port_change |=> !port_ctl.flag)
    else $error("port clear did not drop request");

  a_port_disable_quiet: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    !port_change_irq_enable |=> !port_ctl.flag)
    else $error("port request while disabled");

  a_bus_irq_merge: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    port_ctl.flag || iso_ctl.flag || (other_irq != 2'b00) |-> bus_irq)
    else $error("bus request missing while a circuit requests");

  a_level_readback: assert property (@(posedge clock) disable iff (!rst_n) // [R8] [R13]
    rd_level |=> bus_rdata[3:0] == ($past(opto_sync) ^ {4{$past(input_sense_jumper_flag)}}))
    else $error("opto levels read back with wrong polarity");

  a_edge_needs_enable: assert property (@(posedge clock) disable iff (!rst_n) // [R9]
    ##1 (isolated_edge_flags & ~$past(isolated_edge_flags) & ~$past(edge_cfg.enable)) == 4'h0)
    else $error("edge flag set on disabled channel");

  a_read_clears_flags: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
    s_level_read_quiet |=> isolated_edge_flags == 4'h0)
    else $error("edge flags survive a read");

  a_edge_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
    !rd_level |=> (isolated_edge_flags & $past(isolated_edge_flags)) == $past(isolated_edge_flags))
    else $error("edge flag lost before read");

  a_iso_edge_irq: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
    isolated_irq_enable && (new_edges != 4'h0) |=> iso_ctl.flag)
    else $error("opto edge missed by isolated interrupt");

  a_iso_clear_drops: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
    isolated_irq_clear && (new_edges == 4'h0) |=> !iso_ctl.flag)
    else $error("isolated clear did not drop request");

  a_flags_readback: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    rd_level |=> bus_rdata[7:4] == $past(isolated_edge_flags))
    else $error("edge flags not in upper nibble of level read");

  a_jumper_readback: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
    bus_read && (bus_addr == `DOE_OFS_JUMPER) |=> bus_rdata == {7'h00, $past(input_sense_jumper_flag)})
    else $error("jumper flag read back wrong");

endmodule : dio_opto_edge_interrupt

/* tb/field_lines_model.sv */
`timescale 1ns/1ps

// far side: external wiring of the port lines and the opto field voltages
module field_lines_model
  import dio_opto_pkg::*;
(
  input  wire line_vec_t dio_out,
  input  wire line_vec_t dio_oe_n,
  input  wire line_vec_t ext_en,
  input  wire line_vec_t ext_val,
  input  wire line_vec_t opto_volt,
  output line_vec_t      dio_in,
  output line_vec_t      opto_high
);
  // undriven lines sit at the pull-up level; a line whose own output is on shows it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!dio_oe_n[i]) dio_in[i] = dio_out[i];
      else if (ext_en[i]) dio_in[i] = ext_val[i];
      else dio_in[i] = 1'b1;
    end
  end

  // opto voltage sense passed through: 1 means above the high threshold
  assign opto_high = opto_volt;
endmodule : field_lines_model

/* tb/tb_dio_opto_edge_interrupt.sv */
`timescale 1ns/1ps

module tb_dio_opto_edge_interrupt;
  import dio_opto_pkg::*;

  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  bus_addr_t  bus_addr = 4'h0;
  logic       bus_write = 1'b0;
  logic       bus_read = 1'b0;
  bus_byte_t  bus_wdata = 8'h00;
  bus_byte_t  bus_rdata;
  line_vec_t  dio_in;
  line_vec_t  dio_out;
  line_vec_t  dio_oe_n;
  line_vec_t  opto_high;
  logic       jumper_installed = 1'b0;
  logic [1:0] other_irq = 2'h0;
  logic       bus_irq;
  line_vec_t  ext_en = 4'h0;
  line_vec_t  ext_val = 4'h0;
  line_vec_t  opto_volt = 4'h0;
  int         fails = 0;
  int         n_checks = 0;
  int         cycles = 0;

  always #12.5 clock = ~clock;

  dio_opto_edge_interrupt dio_opto_edge_interrupt_i (
    .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe_n(dio_oe_n), .opto_high(opto_high),
    .jumper_installed(jumper_installed), .other_irq(other_irq), .bus_irq(bus_irq)
  );

  field_lines_model field_lines_model_i (
    .dio_out(dio_out), .dio_oe_n(dio_oe_n), .ext_en(ext_en), .ext_val(ext_val),
    .opto_volt(opto_volt), .dio_in(dio_in), .opto_high(opto_high)
  );

  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input bus_addr_t a, input bus_byte_t d);
    @(negedge clock);
    bus_addr = a;
    bus_wdata = d;
    bus_write = 1'b1;
    @(negedge clock);
    bus_write = 1'b0;
  endtask : wr

  task automatic rd(input bus_addr_t a, output bus_byte_t d);
    @(negedge clock);
    bus_addr = a;
    bus_read = 1'b1;
    @(negedge clock);
    bus_read = 1'b0;
    d = bus_rdata;
  endtask : rd

  // pin to flag takes three clock edges: two synchroniser stages, then the flag register
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask : settle

  task automatic t_reset();
    bus_byte_t d;
    chk({4'h0, dio_oe_n}, 8'h0f);
    chk({4'h0, dio_out}, 8'h00);
    rd(4'h4, d);
    chk(d, 8'h00);
    rd(4'h5, d);
    chk(d & 8'h0f, 8'h0f);
    rd(4'hb, d);
    chk(d, 8'h00);
    wr(4'h7, 8'hff);
    wr(4'h3, 8'hff);
    rd(4'h0, d);
    chk(d, 8'h00);
    rd(4'h7, d);
    chk(d, 8'h00);
  endtask : t_reset

  task automatic t_port_dir();
    bus_byte_t d;
    wr(4'h4, 8'h05);
    wr(4'h5, 8'h0a);
    ext_en = 4'ha;
    ext_val = 4'h2;
    settle();
    chk({4'h0, dio_oe_n}, 8'h0a);
    chk({4'h0, dio_out}, 8'h0a);
    rd(4'h4, d);
    chk(d & 8'h0f, 8'h05);
    rd(4'h5, d);
    chk(d & 8'h0f, 8'h02);
    ext_en = 4'h0;
    settle();
    rd(4'h5, d);
    chk(d & 8'h0f, 8'h0a);
    wr(4'h4, 8'h00);
    settle();
  endtask : t_port_dir

  task automatic t_port_irq();
    bus_byte_t d;
    wr(4'hb, 8'h01);
    settle();
    ext_en = 4'h1;
    ext_val = 4'h0;
    settle();
    rd(4'hb, d);
    chk(d, 8'h05);
    chk({7'h0, bus_irq}, 8'h01);
    ext_en = 4'h0;
    settle();
    rd(4'hb, d);
    chk(d, 8'h05);
    wr(4'hb, 8'h11);
    rd(4'hb, d);
    chk(d, 8'h01);
    chk({7'h0, bus_irq}, 8'h00);
    ext_en = 4'h1;
    settle();
    chk({7'h0, bus_irq}, 8'h01);
    wr(4'hb, 8'h00);
    rd(4'hb, d);
    chk(d, 8'h00);
    ext_en = 4'h0;
    settle();
    rd(4'hb, d);
    chk(d, 8'h00);
    chk({7'h0, bus_irq}, 8'h00);
  endtask : t_port_irq

  task automatic t_opto_edges();
    bus_byte_t d;
    wr(4'h6, 8'h13);
    rd(4'h6, d);
    chk(d, 8'h13);
    rd(4'h7, d);
    opto_volt = 4'h7;
    settle();
    rd(4'h7, d);
    chk(d, 8'h17);
    rd(4'h7, d);
    chk(d, 8'h07);
    opto_volt = 4'h1;
    settle();
    opto_volt = 4'h7;
    settle();
    rd(4'h7, d);
    chk(d, 8'h27);
    opto_volt = 4'h0;
    settle();
    rd(4'h7, d);
    chk(d, 8'h20);
  endtask : t_opto_edges

  task automatic t_jumper();
    bus_byte_t d;
    jumper_installed = 1'b1;
    settle();
    rd(4'h8, d);
    chk(d & 8'h01, 8'h01);
    rd(4'h7, d);
    rd(4'h7, d);
    chk(d, 8'h0f);
    opto_volt = 4'h3;
    settle();
    rd(4'h7, d);
    chk(d, 8'h2c);
    opto_volt = 4'h2;
    settle();
    rd(4'h7, d);
    chk(d, 8'h1d);
    jumper_installed = 1'b0;
    settle();
    rd(4'h8, d);
    chk(d & 8'h01, 8'h00);
    rd(4'h7, d);
  endtask : t_jumper

  task automatic t_shared_irq();
    bus_byte_t d;
    wr(4'hb, 8'h03);
    opto_volt = 4'h3;
    settle();
    rd(4'hb, d);
    chk(d, 8'h0b);
    ext_en = 4'h1;
    ext_val = 4'h0;
    settle();
    rd(4'hb, d);
    chk(d, 8'h0f);
    wr(4'hb, 8'h13);
    rd(4'hb, d);
    chk(d, 8'h0b);
    chk({7'h0, bus_irq}, 8'h01);
    wr(4'hb, 8'h23);
    rd(4'hb, d);
    chk(d, 8'h03);
    chk({7'h0, bus_irq}, 8'h00);
    @(negedge clock);
    other_irq = 2'h2;
    @(negedge clock);
    chk({7'h0, bus_irq}, 8'h01);
    other_irq = 2'h0;
    wr(4'hb, 8'h00);
    ext_en = 4'h0;
    settle();
    chk({7'h0, bus_irq}, 8'h00);
  endtask : t_shared_irq

  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    settle();
    t_reset();
    t_port_dir();
    t_port_irq();
    t_opto_edges();
    t_jumper();
    t_shared_irq();
    tally_and_finish();
  end
endmodule : tb_dio_opto_edge_interrupt
